//--- src/mmd_pkg.sv
// Constants, tables and types for the memory map decoder and SFR bank
// What this block does
// RULE1: Decoder takes a 20-bit address spanning the whole 1-Mbyte space.
// RULE2: Program ROM ends at 0FFFFh, grows down; 16 Kbyte covers 0C000h-0FFFFh.
// RULE3: Fixed vector table sits at 0FFDCh-0FFFFh, holding routine start addresses.
// RULE4: Data flash window 02400h-02BFFh decodes to data flash, not program ROM.
// RULE5: Internal RAM starts at 00400h; 1 Kbyte ends at 007FFh.
// RULE6: Internal RAM serves as data store and as the call and interrupt stack.
// RULE7: Lowest region 00000h-002FFh decodes to the peripheral register bank.
// RULE8: Unassigned register addresses are reserved; no storage, software stays off.
// RULE9: Processor mode 0 at 0004h resets to 00h; mode 1 at 0005h also 00h.
// RULE10: Clock control 0 at 0006h resets to 01101000b.
// RULE11: Clock control 1 at 0007h resets to 00100000b.
// RULE12: Oscillation stop detect at 000Ch resets with only bit 2 set.
// RULE13: Watchdog control at 000Fh resets with low five bits set.
// RULE14: Watchdog refresh and start registers have undefined content after reset.
// RULE15: Voltage detect 1 at 0031h resets with only bit 3 set.
// RULE16: Voltage monitor 1 control resets to 0000X000b, bit 3 undefined.
// RULE17: Voltage registers survive software, watchdog and monitor 2 resets; soft_rst keeps only bits 2 and 3 of the one at 0037h.
// RULE18: All bank registers are eight bits; all but watchdog refresh and start reset with the device reset.
package mmd_pkg;

	// CPU address space and regions
	localparam int          ADDR_W  = 20;
	localparam logic [19:0] SFR_LO  = 20'h00000;
	localparam logic [19:0] SFR_HI  = 20'h002ff;
	localparam logic [19:0] RAM_LO  = 20'h00400;
	localparam logic [19:0] RAM_HI  = 20'h007ff;
	localparam logic [19:0] DFL_LO  = 20'h02400;
	localparam logic [19:0] DFL_HI  = 20'h02bff;
	localparam logic [19:0] ROM_LO  = 20'h0c000;
	localparam logic [19:0] ROM_HI  = 20'h0ffff;
	localparam logic [19:0] VEC_LO  = 20'h0ffdc;

	// APB side: register index times four is the byte address
	localparam int APB_AW = 12;
	localparam int IDX_W  = 10;
	localparam int N_REG  = 25;

	// Protect groups: which write_protect bit opens a register
	localparam logic [1:0] GRP_NONE = 2'h0;
	localparam logic [1:0] GRP_CLK  = 2'h1;
	localparam logic [1:0] GRP_MODE = 2'h2;
	localparam logic [1:0] GRP_VOLT = 2'h3;
	localparam int PROT_CLK_BIT  = 0;
	localparam int PROT_MODE_BIT = 1;
	localparam int PROT_VOLT_BIT = 3;

	// Arbitrary factory trim stand-in for fast_osc_ctrl_1
	localparam logic [7:0] FAST_OSC_TRIM_RST = 8'h00;

	// Entry numbers used outside the table walk
	localparam int E_PM0  = 0;
	localparam int E_PM1  = 1;
	localparam int E_CM0  = 2;
	localparam int E_CM1  = 3;
	localparam int E_WRITE_PROTECT = 5;
	localparam int E_WATCHDOG_REFRESH = 7;
	localparam int E_WATCHDOG_START = 8;
	localparam int E_WDC  = 9;

	// Register index per entry
	localparam logic [IDX_W-1:0] REG_IDX [N_REG] = '{
		10'h004, 10'h005, 10'h006, 10'h007, 10'h009,
		10'h00a, 10'h00c, 10'h00d, 10'h00e, 10'h00f,
		10'h010, 10'h011, 10'h012, 10'h013, 10'h014,
		10'h015, 10'h01c, 10'h01e, 10'h020, 10'h021,
		10'h022, 10'h031, 10'h032, 10'h036, 10'h037};

	// Reset value per entry
	localparam logic [7:0] REG_RST [N_REG] = '{
		8'h00, 8'h00, 8'h68, 8'h20, 8'h00,
		8'h00, 8'h04, 8'h00, 8'h00, 8'h1f,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, FAST_OSC_TRIM_RST,
		8'h00, 8'h08, 8'h00, 8'h00, 8'h00};

	// Bits that a software-class reset leaves alone
	localparam logic [7:0] REG_KEEP [N_REG] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'hff, 8'hff, 8'hff, 8'h0c};

	// Protect group per entry
	localparam logic [1:0] REG_GRP [N_REG] = '{
		GRP_MODE, GRP_MODE, GRP_CLK, GRP_CLK, GRP_NONE,
		GRP_NONE, GRP_CLK, GRP_NONE, GRP_NONE, GRP_NONE,
		GRP_NONE, GRP_NONE, GRP_NONE, GRP_NONE, GRP_NONE,
		GRP_NONE, GRP_NONE, GRP_NONE, GRP_CLK, GRP_CLK,
		GRP_CLK, GRP_VOLT, GRP_VOLT, GRP_VOLT, GRP_VOLT};

	// Entries with no reset at all (bit n = entry n)
	localparam logic [N_REG-1:0] REG_NORST = 25'h0000180;

	typedef struct packed {
		logic sfr;
		logic ram;
		logic dflash;
		logic rom;
		logic vector;
		logic none;
	} mmd_region_type;

	typedef struct packed {
		logic [7:0] proc_mode_0;
		logic [7:0] proc_mode_1;
		logic [7:0] sys_clk_0;
		logic [7:0] sys_clk_1;
		logic [7:0] write_protect;
		logic [7:0] watchdog_control;
	} mmd_ctrl_type;

endpackage

//--- src/mmd_sfr_bank.sv
// Memory map decoder and first peripheral register bank with APB slave
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
module mmd_sfr_bank (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         soft_rst,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [mmd_pkg::APB_AW-1:0]   paddr,
	input  wire logic [31:0]                  pwdata,
	input  wire logic [3:0]                   pstrb,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         cpu_valid,
	input  wire logic [mmd_pkg::ADDR_W-1:0]   cpu_addr,
	output mmd_pkg::mmd_region_type           region,
	output mmd_pkg::mmd_ctrl_type             ctrl,
	output logic                              wdt_refresh_p,
	output logic                              wdt_start_p
);
	import mmd_pkg::*;

	// Region decode of one CPU address; vector table also flags rom
	function automatic mmd_region_type decode_region(
		input logic [ADDR_W-1:0] a
	);
		mmd_region_type r;
		r        = '0;
		r.sfr    = (a <= SFR_HI);                   // [RULE7]
		r.ram    = (a >= RAM_LO) && (a <= RAM_HI);  // [RULE5] [RULE6]
		r.dflash = (a >= DFL_LO) && (a <= DFL_HI);  // [RULE4]
		r.rom    = (a >= ROM_LO) && (a <= ROM_HI);  // [RULE2]
		r.vector = (a >= VEC_LO) && (a <= ROM_HI);  // [RULE3]
		r.none   = ~(r.sfr | r.ram | r.dflash | r.rom);
		return r;
	endfunction

	// Write permission from the group and the write_protect byte
	function automatic logic prot_open(
		input logic [1:0] grp,
		input logic [7:0] prot
	);
		logic ok;
		ok = 1'b1;
		case (grp)
			GRP_CLK:  ok = prot[PROT_CLK_BIT];
			GRP_MODE: ok = prot[PROT_MODE_BIT];
			GRP_VOLT: ok = prot[PROT_VOLT_BIT];
			default:  ok = 1'b1;
		endcase
		return ok;
	endfunction

	logic [7:0]       bank [N_REG];
	logic [N_REG-1:0] hit;
	logic [N_REG-1:0] wr_en;
	logic [7:0]       rd_byte;
	logic             pready_r;

	// APB phase decode; only word-aligned addresses can hit a register
	wire             setup_ph = psel & ~penable;
	wire             done_ph  = psel & penable & pready_r;
	wire             aligned  = (paddr[1:0] == 2'b00);
	wire [IDX_W-1:0] idx      = paddr[APB_AW-1:2];
	wire             mapped   = |hit;
	wire             wr_ok    = done_ph & pwrite & pstrb[0];

	// Per-entry decode and write enables
	genvar i;
	generate
		for (i = 0; i < N_REG; i++) begin : g_reg
			logic [7:0] q;
			assign hit[i]   = aligned && (idx == REG_IDX[i]);
			assign wr_en[i] = wr_ok & hit[i] &
				prot_open(REG_GRP[i], bank[E_WRITE_PROTECT]);
			assign bank[i]  = q;
			if (REG_NORST[i]) begin : g_norst
				// No reset: content undefined until written [RULE14]
				always_ff @(posedge pclk) begin
					if (wr_en[i]) begin
						q <= pwdata[7:0];
					end
				end
			end else begin : g_rst
				// Soft reset spares the kept bits [RULE17]
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						// [RULE18] [RULE9] [RULE10] [RULE11] [RULE12]
						// [RULE13] [RULE15] [RULE16]
						q <= REG_RST[i];
					end else if (soft_rst) begin
						q <= (q & REG_KEEP[i]) |
							(REG_RST[i] & ~REG_KEEP[i]); // [RULE17]
					end else if (wr_en[i]) begin
						q <= pwdata[7:0];
					end
				end
			end
		end
	endgenerate

	// Read mux; reserved addresses read zero and hold nothing [RULE8]
	always_comb begin
		rd_byte = '0;
		for (int k = 0; k < N_REG; k++) begin
			if (hit[k]) begin
				rd_byte = rd_byte | bank[k];
			end
		end
	end

	// Zero-wait answer: ready rises in the cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata   <= '0;
			pslverr  <= 1'b0;
		end else if (setup_ph) begin
			pready_r <= 1'b1;
			prdata   <= {24'h000000, rd_byte};
			pslverr  <= ~mapped; // [RULE8]
		end else begin
			pready_r <= 1'b0;
			prdata   <= '0;
			pslverr  <= 1'b0;
		end
	end
	assign pready = pready_r;

	// Watchdog strobes: a write, not the stored byte, is the event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_refresh_p <= 1'b0;
			wdt_start_p   <= 1'b0;
		end else begin
			wdt_refresh_p <= wr_en[E_WATCHDOG_REFRESH];
			wdt_start_p   <= wr_en[E_WATCHDOG_START];
		end
	end

	// CPU address decode, registered so region is a clean flop output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			region <= '0;
		end else if (cpu_valid) begin
			region <= decode_region(cpu_addr); // [RULE1]
		end else begin
			region <= '0;
		end
	end

	// Control bytes exported straight from the bank flops
	assign ctrl.proc_mode_0      = bank[E_PM0];
	assign ctrl.proc_mode_1      = bank[E_PM1];
	assign ctrl.sys_clk_0        = bank[E_CM0];  // [RULE10]
	assign ctrl.sys_clk_1        = bank[E_CM1];  // [RULE11]
	assign ctrl.write_protect    = bank[E_WRITE_PROTECT];
	assign ctrl.watchdog_control = bank[E_WDC];  // [RULE13]

endmodule

//--- test/mmd_sfr_bank_props.sv
// Port checker for the decoder and register bank
`timescale 1ns/100ps
module mmd_sfr_bank_props
	import mmd_pkg::*;
(
	input wire logic		pclk,
	input wire logic		presetn,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [APB_AW-1:0]	paddr,
	input wire logic [3:0]		pstrb,
	input wire logic		pready,
	input wire logic		pslverr,
	input wire logic		cpu_valid,
	input wire logic [ADDR_W-1:0]	cpu_addr,
	input mmd_region_type		region,
	input mmd_ctrl_type		ctrl,
	input wire logic		wdt_refresh_p
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Setup and completed-write qualifiers
	wire setup = psel && !penable;
	wire wr_done = psel && penable && pready && pwrite && pstrb[0];
	wire [19:0] a = cpu_addr;

	AST_RSVD: assert property (
		setup && paddr == 12'h020 |=> pready && pslverr) else $error("reserved");
	AST_REG_OK: assert property (
		setup && paddr == 12'h018 |=> pready && !pslverr) else $error("ready");
	AST_SFR: assert property (
		cpu_valid && a <= 20'h002ff |=> region.sfr) else $error("sfr");
	AST_RAM: assert property (
		cpu_valid && a >= 20'h00400 && a <= 20'h007ff |=> region.ram)
		else $error("ram");
	AST_DFL: assert property (
		cpu_valid && a >= 20'h02400 && a <= 20'h02bff |=> region.dflash
		&& !region.rom) else $error("dflash");
	AST_ROM: assert property (
		cpu_valid && a >= 20'h0c000 && a <= 20'h0ffff |=> region.rom)
		else $error("rom");
	AST_VEC: assert property (
		cpu_valid && a >= 20'h0ffdc && a <= 20'h0ffff |=> region.vector)
		else $error("vector");
	AST_TOP: assert property (
		cpu_valid && a > 20'h0ffff |=> region.none && !region.rom)
		else $error("top");
	AST_RST: assert property (
		$rose(presetn) |-> ctrl.sys_clk_0 == 8'h68 && ctrl.sys_clk_1 ==
		8'h20 && ctrl.watchdog_control == 8'h1f) else $error("reset");
	AST_WDT: assert property (
		wr_done && paddr == 12'h034 |=> wdt_refresh_p) else $error("pulse");
endmodule

bind mmd_sfr_bank mmd_sfr_bank_props u_props (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pstrb, .pready, .pslverr, .cpu_valid,
	.cpu_addr, .region, .ctrl, .wdt_refresh_p);

//--- test/mmd_cpu_model.sv
// Behavioural CPU core issuing address-space accesses
`timescale 1ns/100ps
module mmd_cpu_model
	import mmd_pkg::*;
(
	input wire logic		pclk,
	output logic			cpu_valid,
	output logic [ADDR_W-1:0]	cpu_addr
);
	initial begin
		cpu_valid = 1'b0;
		cpu_addr = '0;
	end
	// One access per call; idle cycles invert the address so a stale
	// value never looks like a live one
	task automatic fetch(input logic [ADDR_W-1:0] ad, input logic v);
		@(posedge pclk);
		cpu_valid <= v;
		cpu_addr <= v ? ad : ~cpu_addr;
	endtask
endmodule

//--- test/test_mmd_sfr_bank.sv
// Self-checking bench for the decoder and register bank
`timescale 1ns/100ps
module test_mmd_sfr_bank;
	import mmd_pkg::*;
	logic		pclk, presetn, soft_rst, psel, penable, pwrite;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata;
	logic [3:0]	pstrb;
	logic		pready, pslverr, cpu_valid, wdt_refresh_p, wdt_start_p;
	logic [19:0]	cpu_addr;
	logic [7:0]	d;
	logic [1:0]	wdt_exp = 2'h0;
	mmd_region_type	region;
	mmd_ctrl_type	ctrl;
	int		bad_count, cmp_count, seed, v_d;
	logic [32:0]	apb_q[$];
	mmd_region_type	reg_q[$];
	logic [19:0]	edges[14] = '{20'h00000, 20'h002ff, 20'h00300,
		20'h00400, 20'h007ff, 20'h02400, 20'h02bff, 20'h02c00,
		20'h0bfff, 20'h0c000, 20'h0ffdb, 20'h0ffdc, 20'h10000, 20'hfffff};

	mmd_sfr_bank u_mmd_sfr_bank (.pclk, .presetn, .soft_rst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .cpu_valid, .cpu_addr, .region, .ctrl, .wdt_refresh_p,
		.wdt_start_p);
	mmd_cpu_model u_mmd_cpu_model (.pclk, .cpu_valid, .cpu_addr);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic note(string n, logic [32:0] e, logic [32:0] s);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask

	// Write results only carry the error flag
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			if (pwrite)
				note("err", apb_q[0][32], pslverr);
			else
				note("rdata", apb_q[0], {pslverr, prdata});
			void'(apb_q.pop_front());
		end
		if (v_d)
			note("region", reg_q.pop_front(), region);
		v_d <= cpu_valid;
		// Watchdog strobes follow an accepted write by one cycle
		note("wdt", wdt_exp, {wdt_start_p, wdt_refresh_p});
		wdt_exp <= {2{psel && penable && pready && pwrite && pstrb[0]}} &
			{paddr == 12'h038, paddr == 12'h034};
	end

	// Holds the request until pready is seen, as APB requires
	task automatic apb(logic w, logic [9:0] i, logic [7:0] wd,
		logic [7:0] e, logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, wd};
		apb_q.push_back({err, 24'h0, e});
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic mmd_region_type exp_reg(logic [19:0] x);
		exp_reg = '0;
		exp_reg.sfr = x <= SFR_HI;
		exp_reg.ram = x >= RAM_LO && x <= RAM_HI;
		exp_reg.dflash = x >= DFL_LO && x <= DFL_HI;
		exp_reg.rom = x >= ROM_LO && x <= ROM_HI;
		exp_reg.vector = x >= VEC_LO && x <= ROM_HI;
		exp_reg.none = !(exp_reg[5:4] || exp_reg[3:2]);
	endfunction

	task automatic fetch(logic [19:0] x);
		reg_q.push_back(exp_reg(x));
		u_mmd_cpu_model.fetch(x, 1'b1);
	endtask

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Runaway guard well beyond the sequence length
	initial begin
		#(40 * 4000);
		bad_count++;
		wrap_up();
	end

	initial begin
		seed = 73;
		{presetn, soft_rst, psel, penable, pwrite} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// Every entry with a defined reset value reads it back
		for (int e = 0; e < N_REG; e++)
			if (!REG_NORST[e])
				apb(0, REG_IDX[e], 0, REG_RST[e], 0);
		apb(0, 10'h008, 0, 0, 1);
		apb(1, 10'h0c0, 8'h55, 0, 1);
		// Locked clock register ignores the write
		apb(1, 10'h006, 8'h00, 0, 0);
		apb(0, 10'h006, 0, 8'h68, 0);
		apb(1, 10'h00a, 8'h0b, 0, 0);
		d = 8'($random(seed));
		apb(1, 10'h004, d, 0, 0);
		apb(1, 10'h031, ~d, 0, 0);
		apb(1, 10'h00d, d, 0, 0);
		apb(1, 10'h00e, ~d, 0, 0);
		@(posedge pclk);
		soft_rst <= 1'b1;
		@(posedge pclk);
		soft_rst <= 1'b0;
		apb(0, 10'h004, 0, 8'h00, 0);
		apb(0, 10'h031, 0, ~d, 0);
		apb(0, 10'h00d, 0, d, 0);
		apb(0, 10'h00e, 0, ~d, 0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 10'h031, 0, 8'h08, 0);
		foreach (edges[i])
			fetch(edges[i]);
		repeat (40) fetch(20'($random(seed)));
		u_mmd_cpu_model.fetch(20'h0, 1'b0);
		repeat (3) @(posedge pclk);
		wrap_up();
	end
endmodule
